/* logic/tmsel_pkg.sv */
//
// Contract
// [RULE1] Master mode: all outputs come from DPLL
// [RULE2] Master: input clock/frame supplied from DPLL
// [RULE3] Master: stream peers follow device output timing
// [RULE4] Master: DPLL locks to one of four references
// [RULE5] Master: streams timed by DPLL clock
// [RULE6] Master external clock aligned to primary outputs
// [RULE7] Divided slave: outputs divided from input timing
// [RULE8] Divided slave: streams and primaries use input clock
// [RULE9] Divided slave: output rate never above input
// [RULE10] Multiplied slave: streams timed by multiplied clock; code drives with it but samples on the input clock
// [RULE11] Multiplied slave: primaries from clock multiplier
// [RULE12] Slave DPLL off unless enable bit set
// [RULE13] Slave DPLL drives fifth, sixth, PLL frame only
// [RULE14] Bidirectional pin: sample or drive clock per direction
// [RULE15] Mode field 00/01/11; loopback bit in master
// [RULE16] Low-rate select 11=4M, 00=8/16M input
// [RULE17] No oscillator: slave DPLL and fifth/sixth off
//
package tmsel_pkg;

   // ****************************************************
   // Mode field encodings
   // ****************************************************
   localparam logic [1:0] TMSEL_OPM_MASTER = 2'h0; // DPLL timed
   localparam logic [1:0] TMSEL_OPM_DIV = 2'h1;    // Divided slave
   localparam logic [1:0] TMSEL_OPM_MULT = 2'h3;   // Multiplied slave

   // ****************************************************
   // Low-rate input select encodings
   // ****************************************************
   localparam logic [1:0] TMSEL_LR_4M = 2'h3;      // 4 MHz input clock
   localparam logic [1:0] TMSEL_LR_HIGH = 2'h0;    // 8 or 16 MHz input clock

   // ****************************************************
   // Stream data rate codes
   // ****************************************************
   localparam logic [1:0] TMSEL_RATE_2M = 2'h0;    // 2.048 Mbps
   localparam logic [1:0] TMSEL_RATE_4M = 2'h1;    // 4.096 Mbps
   localparam logic [1:0] TMSEL_RATE_8M = 2'h2;    // 8.192 Mbps
   localparam logic [1:0] TMSEL_RATE_16M = 2'h3;   // 16.384 Mbps

   // ****************************************************
   // Reference and structure constants
   // ****************************************************
   localparam int TMSEL_NUM_REFS = 4;              // DPLL reference inputs
   localparam int TMSEL_NUM_PRIMARY = 4;           // Primary clock outputs
   localparam int TMSEL_NUM_FP = 4;                // Frame pulse outputs
   localparam logic [2:0] TMSEL_REF_FREQ_MAX = 3'h6; // Codes 0..6: 8k..19.44M
   localparam int TMSEL_MULT_FACTOR = 4;           // Input clock multiplication
   localparam int TMSEL_MEAS_W = 8;                // Half period counter width
   localparam int TMSEL_PERIOD_NS = 10;            // ref_clk period
   localparam int TMSEL_OUT_LAT = 1;               // Input to output cycles

   // ****************************************************
   // Decoded timing mode
   // ****************************************************
   typedef enum {
      TMSEL_M_MASTER,
      TMSEL_M_DIV,
      TMSEL_M_MULT,
      TMSEL_M_BAD
   } tmsel_mode_t;

endpackage

/* logic/tmsel_clk_mult.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************
// Input clock multiplier
// ****************************************************
module tmsel_clk_mult
   import tmsel_pkg::*;
#(
   parameter int FACTOR = TMSEL_MULT_FACTOR,
   parameter int CNT_W = TMSEL_MEAS_W
) (
   input wire logic ref_clk, // System clock
   input wire logic rst,     // Async reset, high
   input wire logic in_clk,  // Sampled input clock level
   output logic mult_clk     // Multiplied clock level
);

   localparam int SHIFT = $clog2(FACTOR); // Divide half period

   // Refuse non power of two factors
   initial begin
      if (FACTOR < 2 || (1 << SHIFT) != FACTOR) begin
         $error("tmsel_clk_mult: FACTOR must be a power of two");
      end
   end

   logic prev_reg, prev_next;            // Last input level
   logic [CNT_W-1:0] cnt_reg, cnt_next;  // Cycles since edge
   logic [CNT_W-1:0] half_reg, half_next; // Measured half period
   logic [CNT_W-1:0] ph_reg, ph_next;    // Phase within step
   logic out_reg, out_next;              // Output level
   logic [CNT_W-1:0] step;               // Cycles per output half

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      step = half_reg >> SHIFT;
      if (step == '0) begin
         step = {{(CNT_W-1){1'b0}}, 1'b1};
      end
      prev_next = in_clk;
      cnt_next = cnt_reg;
      half_next = half_reg;
      ph_next = ph_reg + 1'b1;
      out_next = out_reg;
      if (in_clk != prev_reg) begin
         // Edge: resync phase to the input
         half_next = cnt_reg + 1'b1;
         cnt_next = '0;
         ph_next = '0;
         out_next = 1'b1; // Input edges land on fast clock rising edges
      end else begin
         if (cnt_reg != '1) begin
            cnt_next = cnt_reg + 1'b1;
         end
         if (ph_reg + 1'b1 >= step) begin
            ph_next = '0;
            out_next = ~out_reg;
         end
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prev_reg <= 1'b0;
         cnt_reg <= '0;
         half_reg <= '0;
         ph_reg <= '0;
         out_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         cnt_reg <= cnt_next;
         half_reg <= half_next;
         ph_reg <= ph_next;
         out_reg <= out_next;
      end
   end

   assign mult_clk = out_reg;

endmodule

`default_nettype wire

/* logic/tmsel_core.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************
// Timing mode selection and clock routing
// ****************************************************
module tmsel_core
   import tmsel_pkg::*;
#(
   parameter int NUM_PINS = 32 // Bidirectional stream pins
) (
   input wire logic ref_clk,                             // System clock
   input wire logic rst,                                 // Async reset, high
   input wire logic [1:0] operating_mode_field,          // Mode select
   input wire logic input_clock_loopback,                // Master loopback
   input wire logic slave_pll_enable,                    // DPLL in slave
   input wire logic oscillator_present,                  // Oscillator fitted
   input wire logic [1:0] low_rate_input_select,         // Input clock rate
   input wire logic input_clock_high,                    // 1 = 16 MHz input
   input wire logic [1:0] out_rate_req,                  // Wanted stream rate
   input wire logic input_clock,                         // Input clock level
   input wire logic input_frame_pulse,                   // Input frame pulse
   input wire logic [TMSEL_NUM_REFS-1:0] pll_reference_inputs, // References
   input wire logic [1:0] ref_select,                    // Chosen reference
   input wire logic [2:0] ref_freq_code,                 // Reference rate
   input wire logic [TMSEL_NUM_PRIMARY-1:0] pll_primary, // DPLL primaries
   input wire logic pll_fifth,                           // DPLL fifth clock
   input wire logic pll_sixth,                           // DPLL sixth clock
   input wire logic [TMSEL_NUM_FP-1:0] pll_frame,        // DPLL frame pulses
   input wire logic pll_frame5,                          // DPLL frame pulse 5
   input wire logic [NUM_PINS-1:0] pin_is_output,        // Pin direction
   output logic [TMSEL_NUM_PRIMARY-1:0] primary_clock_outputs, // Primaries
   output logic fifth_clock_output,                      // Fifth clock
   output logic sixth_clock_output,                      // Sixth clock
   output logic [TMSEL_NUM_FP-1:0] frame_pulse_outputs,  // Frame pulses
   output logic pll_frame_pulse_output,                  // DPLL frame pulse
   output logic pll_enable,                              // DPLL running
   output logic ref_monitor_active,                      // Monitoring on
   output logic pll_ref_clock,                           // Chosen reference
   output logic ref_freq_bad,                            // Bad ref code
   output logic mode_bad,                                // Bad mode setting
   output logic rate_refused,                            // Rate too high
   output logic serial_input_sampling,                   // Sampling clock
   output logic serial_output_driving,                   // Driving clock
   output logic [NUM_PINS-1:0] serial_stream_pins_clk,   // Per pin clock
   output logic [NUM_PINS-1:0] serial_stream_pins_oe     // Per pin drive
);

   // Refuse pin counts outside the stream range
   initial begin
      if (NUM_PINS < 1 || NUM_PINS > 32) begin
         $error("tmsel_core: NUM_PINS must be 1 to 32");
      end
   end

   // ****************************************************
   // Declarations
   // ****************************************************
   tmsel_mode_t mode; // Decoded mode
   logic mult_clk;    // Multiplied input clock
   logic [1:0] mdiv_reg, mdiv_next;     // Multiplied clock divider
   logic mult_prev_reg, mult_prev_next; // Last multiplied level
   logic slave; // Either slave mode
   logic pll_on; // DPLL enabled this cycle
   logic [1:0] max_rate; // Highest rate input allows
   logic [TMSEL_NUM_PRIMARY-1:0] mult_taps; // Multiplier taps
   logic [TMSEL_NUM_PRIMARY-1:0] prim_reg, prim_next;
   logic fifth_reg, fifth_next;
   logic sixth_reg, sixth_next;
   logic [TMSEL_NUM_FP-1:0] fp_reg, fp_next;
   logic fp5_reg, fp5_next;
   logic pllen_reg, pllen_next;
   logic refclk_reg, refclk_next;
   logic rfbad_reg, rfbad_next;
   logic mbad_reg, mbad_next;
   logic rref_reg, rref_next;
   logic smp_reg, smp_next;
   logic drv_reg, drv_next;
   logic [NUM_PINS-1:0] pclk_reg, pclk_next;
   logic [NUM_PINS-1:0] poe_reg, poe_next;

   // ****************************************************
   // Clock multiplier
   // ****************************************************
   tmsel_clk_mult #(
      .FACTOR(TMSEL_MULT_FACTOR),
      .CNT_W(TMSEL_MEAS_W)
   ) u_mult (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_clk(input_clock),
      .mult_clk(mult_clk)
   );

   // ****************************************************
   // Mode decode
   // ****************************************************
   always_comb begin
      if (operating_mode_field == TMSEL_OPM_MASTER) begin
         mode = TMSEL_M_MASTER; // [RULE15]
      end else if (operating_mode_field == TMSEL_OPM_DIV) begin
         mode = TMSEL_M_DIV; // [RULE15]
      end else if (operating_mode_field == TMSEL_OPM_MULT) begin
         mode = TMSEL_M_MULT; // [RULE15]
      end else begin
         mode = TMSEL_M_BAD; // Code 10 is not a mode
      end
   end

   // Input clock rate limits the divided stream rate
   always_comb begin
      if (low_rate_input_select == TMSEL_LR_4M) begin
         max_rate = TMSEL_RATE_2M; // [RULE16]
      end else if (input_clock_high) begin
         max_rate = TMSEL_RATE_8M; // [RULE16]
      end else begin
         max_rate = TMSEL_RATE_4M; // [RULE16]
      end
   end

   // Slave DPLL needs enable bit and oscillator
   assign slave = (mode == TMSEL_M_DIV) || (mode == TMSEL_M_MULT);
   assign pll_on = (mode == TMSEL_M_MASTER) ||
                   (slave && slave_pll_enable && oscillator_present); // [RULE12] [RULE17]

   // Divider taps on the multiplied clock
   assign mult_taps = {mult_clk, mult_clk, mdiv_reg[0], mdiv_reg[1]}; // [RULE11]

   // ****************************************************
   // Next output values
   // ****************************************************
   always_comb begin
      mult_prev_next = mult_clk;
      mdiv_next = mdiv_reg;
      if (mult_clk && !mult_prev_reg) begin
         mdiv_next = mdiv_reg + 2'h1;
      end
      prim_next = '0;
      fp_next = '0;
      smp_next = 1'b0;
      drv_next = 1'b0;
      mbad_next = 1'b0;
      rref_next = 1'b0;
      case (mode)
         TMSEL_M_MASTER: begin
            prim_next = pll_primary; // [RULE1] [RULE5]
            fp_next = pll_frame; // [RULE1]
            drv_next = pll_primary[2]; // [RULE5]
            // Loopback samples with DPLL clock too
            smp_next = input_clock_loopback ? pll_primary[2] : input_clock; // [RULE15]
         end
         TMSEL_M_DIV: begin
            prim_next = {TMSEL_NUM_PRIMARY{input_clock}}; // [RULE8]
            fp_next = {TMSEL_NUM_FP{input_frame_pulse}}; // [RULE7]
            smp_next = input_clock; // [RULE8]
            drv_next = input_clock; // [RULE8]
            rref_next = (out_rate_req > max_rate); // [RULE9]
         end
         TMSEL_M_MULT: begin
            prim_next = mult_taps; // [RULE11]
            fp_next = {TMSEL_NUM_FP{input_frame_pulse}};
            smp_next = input_clock;
            drv_next = mult_clk; // [RULE10]
         end
         default: begin
            mbad_next = 1'b1; // All outputs quiet
         end
      endcase
      // Low-rate select codes 01 and 10 are invalid in slave
      if (slave && low_rate_input_select != TMSEL_LR_4M &&
          low_rate_input_select != TMSEL_LR_HIGH) begin
         mbad_next = 1'b1; // [RULE16]
      end
      pllen_next = pll_on; // [RULE12]
      fifth_next = pll_on ? pll_fifth : 1'b0; // [RULE13] [RULE17]
      sixth_next = pll_on ? pll_sixth : 1'b0; // [RULE13] [RULE17]
      fp5_next = pll_on ? pll_frame5 : 1'b0; // [RULE13]
      refclk_next = pll_on ? pll_reference_inputs[ref_select] : 1'b0; // [RULE4]
      rfbad_next = pll_on && (ref_freq_code > TMSEL_REF_FREQ_MAX); // [RULE4]
   end

   // Per pin clock follows the pin direction
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         always_comb begin
            pclk_next[gi] = pin_is_output[gi] ? drv_next : smp_next; // [RULE14]
            poe_next[gi] = pin_is_output[gi] && !rref_next && !mbad_next; // [RULE9]
         end
      end
   endgenerate

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mult_prev_reg <= 1'b0;
         mdiv_reg <= 2'h0;
         prim_reg <= '0;
         fifth_reg <= 1'b0;
         sixth_reg <= 1'b0;
         fp_reg <= '0;
         fp5_reg <= 1'b0;
         pllen_reg <= 1'b0;
         refclk_reg <= 1'b0;
         rfbad_reg <= 1'b0;
         mbad_reg <= 1'b0;
         rref_reg <= 1'b0;
         smp_reg <= 1'b0;
         drv_reg <= 1'b0;
         pclk_reg <= '0;
         poe_reg <= '0;
      end else begin
         mult_prev_reg <= mult_prev_next;
         mdiv_reg <= mdiv_next;
         prim_reg <= prim_next;
         fifth_reg <= fifth_next;
         sixth_reg <= sixth_next;
         fp_reg <= fp_next;
         fp5_reg <= fp5_next;
         pllen_reg <= pllen_next;
         refclk_reg <= refclk_next;
         rfbad_reg <= rfbad_next;
         mbad_reg <= mbad_next;
         rref_reg <= rref_next;
         smp_reg <= smp_next;
         drv_reg <= drv_next;
         pclk_reg <= pclk_next;
         poe_reg <= poe_next;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign primary_clock_outputs = prim_reg;
   assign fifth_clock_output = fifth_reg;
   assign sixth_clock_output = sixth_reg;
   assign frame_pulse_outputs = fp_reg;
   assign pll_frame_pulse_output = fp5_reg;
   assign pll_enable = pllen_reg;
   assign ref_monitor_active = pllen_reg; // [RULE13]
   assign pll_ref_clock = refclk_reg;
   assign ref_freq_bad = rfbad_reg;
   assign mode_bad = mbad_reg;
   assign rate_refused = rref_reg;
   assign serial_input_sampling = smp_reg;
   assign serial_output_driving = drv_reg;
   assign serial_stream_pins_clk = pclk_reg;
   assign serial_stream_pins_oe = poe_reg;

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence master_now_s;
      operating_mode_field == TMSEL_OPM_MASTER;
   endsequence

   sequence div_now_s;
      operating_mode_field == TMSEL_OPM_DIV;
   endsequence

   master_prim_a: assert property (master_now_s |=> primary_clock_outputs == $past(pll_primary)) // [RULE1]
      else $error("master primaries not from DPLL");

   master_drive_a: assert property (master_now_s |=> serial_output_driving == $past(pll_primary[2])) // [RULE5]
      else $error("master stream drive clock wrong");

   ref_pick_a: assert property (master_now_s |=> pll_ref_clock == $past(pll_reference_inputs[ref_select])) // [RULE4]
      else $error("reference selection wrong");

   div_bypass_a: assert property (div_now_s |=> primary_clock_outputs == {4{$past(input_clock)}}) // [RULE8]
      else $error("divided primaries not bypassed");

   div_frame_a: assert property (div_now_s |=> frame_pulse_outputs == {4{$past(input_frame_pulse)}}) // [RULE7]
      else $error("divided frame pulses wrong");

   rate_limit_a: assert property (div_now_s and
      (low_rate_input_select == TMSEL_LR_4M && out_rate_req != TMSEL_RATE_2M)
      |=> rate_refused && serial_stream_pins_oe == '0) // [RULE9]
      else $error("rate above input not refused");

   mult_drive_a: assert property (operating_mode_field == TMSEL_OPM_MULT |=> serial_output_driving == $past(mult_clk)) // [RULE10]
      else $error("multiplied drive clock wrong");

   slave_off_a: assert property ((operating_mode_field != TMSEL_OPM_MASTER) && !slave_pll_enable
      |=> !pll_enable && !fifth_clock_output && !sixth_clock_output) // [RULE12]
      else $error("slave DPLL on without enable");

   no_osc_a: assert property (slave && !oscillator_present |=> !pll_enable ##0 !fifth_clock_output) // [RULE17]
      else $error("DPLL on without oscillator");

   slave_pll_a: assert property (slave && slave_pll_enable && oscillator_present
      |=> fifth_clock_output == $past(pll_fifth) && pll_frame_pulse_output == $past(pll_frame5)
          && ref_monitor_active) // [RULE13]
      else $error("slave DPLL outputs wrong");

   pin_dir_a: assert property (pin_is_output[0] |=> serial_stream_pins_clk[0] == serial_output_driving) // [RULE14]
      else $error("pin clock does not follow direction");

   bad_mode_a: assert property (operating_mode_field == 2'h2 |=> mode_bad && primary_clock_outputs == '0) // [RULE15]
      else $error("invalid mode not flagged");

endmodule

`default_nettype wire

/* sim/tmsel_far_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************
// Far side: timing source, DPLL outputs, references
// ****************************************************
module tmsel_far_model (
   input wire logic ref_clk, // System clock
   input wire logic rst, // Async reset, high
   input wire logic master, // Device in master mode
   output logic in_clk, // Input clock level
   output logic in_fp, // Input frame pulse
   output logic [3:0] dpll_prim, // DPLL primaries
   output logic dpll_fifth, // DPLL fifth clock
   output logic dpll_sixth, // DPLL sixth clock
   output logic [3:0] dpll_frame, // DPLL frame pulses
   output logic dpll_frame5, // DPLL frame pulse 5
   output logic [3:0] refs // Reference levels
);
   logic [9:0] cnt_reg; // Free running timebase

   // Timebase counter
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 10'h0;
      end else begin
         cnt_reg <= cnt_reg + 10'h1;
      end
   end

   // DPLL outputs and references, all from one timebase
   always_comb begin
      dpll_prim = {cnt_reg[0], cnt_reg[1], cnt_reg[2], cnt_reg[3]};
      dpll_fifth = cnt_reg[5];
      dpll_sixth = cnt_reg[1] ^ cnt_reg[3];
      dpll_frame = {4{cnt_reg[7:0] == 8'h0}};
      dpll_frame5 = cnt_reg[7:0] == 8'h1;
      refs = {cnt_reg[6], cnt_reg[4], cnt_reg[2], cnt_reg[9]};
   end

   // Master: timing looped back from DPLL; slave: own slow clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         in_clk <= 1'b0;
         in_fp <= 1'b0;
      end else if (master) begin
         in_clk <= dpll_prim[2];
         in_fp <= dpll_frame[0];
      end else begin
         in_clk <= cnt_reg[4];
         in_fp <= cnt_reg[7:0] == 8'h0;
      end
   end
endmodule

`default_nettype wire

/* sim/tmsel_core_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************
// Self checking bench for timing mode select
// ****************************************************
module tmsel_core_tb_top;
   import tmsel_pkg::*;
   logic ref_clk, rst, lp, en, osc, hi, ic, fp, p5, p6, pf5, v;
   logic [1:0] m, lr, rr, rs;
   logic [2:0] fc;
   logic [3:0] pp, pf, refs, e_prim, e_frm;
   logic [31:0] po, e_oe, e_pc, pc, oe;
   logic [3:0] prim, frm;
   logic c5, c6, f5, on_o, mon, rck, fbad, bad_o, refu, smp, drv;
   logic e_on, e_bad, e_ck, kn, e_ref, e_fb, e_rf, e_smp, e_drv, e_5, e_6, e_f5;
   int err_total, tests_run, seed;

   tmsel_core dut_u (.ref_clk(ref_clk), .rst(rst), .operating_mode_field(m),
      .input_clock_loopback(lp), .slave_pll_enable(en), .oscillator_present(osc),
      .low_rate_input_select(lr), .input_clock_high(hi), .out_rate_req(rr),
      .input_clock(ic), .input_frame_pulse(fp), .pll_reference_inputs(refs),
      .ref_select(rs), .ref_freq_code(fc), .pll_primary(pp), .pll_fifth(p5),
      .pll_sixth(p6), .pll_frame(pf), .pll_frame5(pf5), .pin_is_output(po),
      .primary_clock_outputs(prim), .fifth_clock_output(c5), .sixth_clock_output(c6),
      .frame_pulse_outputs(frm), .pll_frame_pulse_output(f5), .pll_enable(on_o),
      .ref_monitor_active(mon), .pll_ref_clock(rck), .ref_freq_bad(fbad), .mode_bad(bad_o),
      .rate_refused(refu), .serial_input_sampling(smp), .serial_output_driving(drv),
      .serial_stream_pins_clk(pc), .serial_stream_pins_oe(oe));

   tmsel_far_model far_u (.ref_clk(ref_clk), .rst(rst), .master(m == 2'h0), .in_clk(ic),
      .in_fp(fp), .dpll_prim(pp), .dpll_fifth(p5), .dpll_sixth(p6), .dpll_frame(pf),
      .dpll_frame5(pf5), .refs(refs));

   // Clock, 10 ns period
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Value compare
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
      end
   endtask

   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Expected outputs from inputs seen at this edge
   always @(posedge ref_clk) begin
      logic sl, on, rf, s, d;
      logic [1:0] lim;
      sl = m[0];
      e_bad <= (m == 2'h2) || (sl && (lr == 2'h1 || lr == 2'h2));
      e_ck <= !(sl && (lr == 2'h1 || lr == 2'h2));
      on = (m == 2'h0) || (sl && en && osc);
      lim = (lr == 2'h3) ? 2'h0 : (hi ? 2'h2 : 2'h1);
      rf = (m == 2'h1) && (rr > lim);
      e_on <= on;
      e_ref <= on ? refs[rs] : 1'b0;
      e_fb <= on && (fc > TMSEL_REF_FREQ_MAX);
      e_rf <= rf;
      e_5 <= on ? p5 : 1'b0;
      e_6 <= on ? p6 : 1'b0;
      e_f5 <= on ? pf5 : 1'b0;
      kn <= m != 2'h3;
      e_prim <= (m == 2'h0) ? pp : ((m == 2'h1) ? {4{ic}} : 4'h0);
      e_frm <= (m == 2'h0) ? pf : ((m == 2'h2) ? 4'h0 : {4{fp}});
      s = (m == 2'h0) ? (lp ? pp[2] : ic) : ((m == 2'h1) ? ic : 1'b0);
      d = (m == 2'h0) ? pp[2] : ((m == 2'h1) ? ic : 1'b0);
      e_smp <= s;
      e_drv <= d;
      e_pc <= (po & {32{d}}) | (~po & {32{s}});
      e_oe <= (m == 2'h2 || rf) ? 32'h0 : po;
      v <= !rst;
   end

   // Compare registered outputs mid cycle
   always @(negedge ref_clk) begin
      if (v && !rst) begin
         chk(bad_o, e_bad, "mode_bad");
         if (e_ck) begin
            chk({on_o, mon}, {2{e_on}}, "pll on");
            chk({c5, c6, f5}, {e_5, e_6, e_f5}, "fifth sixth");
            chk({rck, fbad}, {e_ref, e_fb}, "reference");
            chk(refu, e_rf, "rate");
            chk(frm, e_frm, "frames");
            chk(oe, e_oe, "pin oe");
         end
         if (e_ck && kn) begin
            chk(prim, e_prim, "primary");
            chk({smp, drv}, {e_smp, e_drv}, "stream clk");
            chk(pc, e_pc, "pin clk");
         end
      end
   end

   // Random per cycle stimulus for n cycles
   task automatic run(input int n);
      logic [31:0] r;
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         r = 32'($random(seed));
         rr <= r[1:0];
         rs <= r[3:2];
         fc <= r[6:4];
         po <= 32'($random(seed));
      end
   endtask

   // Apply one configuration
   task automatic cfg(input logic [1:0] mm, input logic [1:0] ll, input logic [3:0] b);
      @(posedge ref_clk);
      m <= mm;
      lr <= ll;
      {en, osc, hi, lp} <= b;
   endtask

   initial begin
      int mt, it, dt;
      logic pm, pi, pd;
      logic [31:0] r;
      seed = 91;
      err_total = 0;
      tests_run = 0;
      rst = 1'b1;
      {m, lr, rr, rs, fc, po, lp, en, osc, hi} = '0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      for (int k = 0; k < 30; k++) begin
         r = 32'($random(seed));
         cfg((r[1:0] == 2'h2) ? 2'h3 : r[1:0], {2{r[2]}}, r[6:3]);
         run(40);
      end
      $display("random configs done");
      cfg(2'h2, 2'h0, 4'hf);
      run(20);
      cfg(2'h1, 2'h1, 4'hf);
      run(20);
      cfg(2'h3, 2'h3, 4'hb);
      run(20);
      $display("corner modes done");
      cfg(2'h3, 2'h0, 4'hc);
      run(30);
      mt = 0;
      it = 0;
      dt = 0;
      @(negedge ref_clk);
      pm = prim[3];
      pi = ic;
      pd = prim[1];
      for (int i = 0; i < 200; i++) begin
         @(negedge ref_clk);
         mt += int'(prim[3] != pm);
         it += int'(ic != pi);
         dt += int'(prim[1] != pd);
         pm = prim[3];
         pi = ic;
         pd = prim[1];
      end
      chk(32'(it >= 10 && mt >= 3 * it), 32'h1, "multiplied clock");
      chk(32'(2 * dt + 2 >= mt && 2 * dt <= mt + 2), 32'h1, "divided tap");
      $display("multiplier done");
      cfg(2'h0, 2'h0, 4'h1);
      run(10);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(negedge ref_clk);
      chk({prim, c5, c6, frm, f5, on_o, refu, |oe}, 32'h0, "reset");
      @(posedge ref_clk);
      rst <= 1'b0;
      run(30);
      $display("mid reset done");
      summarize;
   end

   // Run length guard
   initial begin
      #1000000;
      err_total++;
      summarize;
   end
endmodule

`default_nettype wire
